// >>> fwsr_pkg.sv
package fwsr_pkg;

    // Clock and flash bus timing.
    localparam int CLK_NS      = 40;
    localparam int T_WP_NS     = 50;
    localparam int T_ACC_NS    = 100;
    localparam int SYNC_CYC    = 3;
    localparam int WE_LOW_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int OE_LOW_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int PHASE_W     = 4;

    // Widths.
    localparam int FA_W = 20;
    localparam int FD_W = 8;

    // Register offsets.
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_RDATA  = 8'h10;

    // Command register fields.
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_NOWAIT   = 4;

    // Status register bit positions.
    localparam int ST_BUSY      = 0;
    localparam int ST_DONE      = 1;
    localparam int ST_FAIL      = 2;
    localparam int ST_REJECT    = 3;
    localparam int ST_WIN_AFTER = 4;
    localparam int ST_RDY       = 5;
    localparam int ST_WIN_PRE   = 6;

    // Status byte bit positions on the flash data bus.
    localparam int BIT_POLL     = 7;
    localparam int BIT_TOGGLE_A = 6;
    localparam int BIT_TIMEOUT  = 5;
    localparam int BIT_WINDOW   = 3;
    localparam int BIT_TOGGLE_B = 2;

    // Flash command addresses and codes.
    localparam logic [FA_W-1:0] UNLOCK_A1 = 20'h00555;
    localparam logic [FA_W-1:0] UNLOCK_A2 = 20'h002aa;
    localparam logic [FD_W-1:0] CODE_AA   = 8'haa;
    localparam logic [FD_W-1:0] CODE_55   = 8'h55;
    localparam logic [FD_W-1:0] CODE_PROG = 8'ha0;
    localparam logic [FD_W-1:0] CODE_ERS  = 8'h80;
    localparam logic [FD_W-1:0] CODE_CHIP = 8'h10;
    localparam logic [FD_W-1:0] CODE_SECT = 8'h30;
    localparam logic [FD_W-1:0] CODE_SUSP = 8'hb0;
    localparam logic [FD_W-1:0] CODE_RES  = 8'h30;
    localparam logic [FD_W-1:0] CODE_RST  = 8'hf0;

    typedef enum logic [2:0] {
        OP_POLL, OP_READ, OP_PROG, OP_SERASE, OP_CERASE, OP_SUSPEND, OP_RESUME, OP_RESET
    } fwsr_op_t;

endpackage

// >>> fwsr_cycle.sv
module fwsr_cycle
    import fwsr_pkg::*;
(
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            rst,
    // Cycle request.
    input  wire logic            start,
    input  wire logic            isWrite,
    input  wire logic [FA_W-1:0] addr,
    input  wire logic [FD_W-1:0] wdata,
    output logic                 done,
    output logic [FD_W-1:0]      rdata,
    output logic                 readyBusy,
    // Flash pins.
    output logic [FA_W-1:0]      flashAddr,
    output logic [FD_W-1:0]      dataOut,
    output logic                 dataOe,
    output logic                 ceN,
    output logic                 oeN,
    output logic                 weN,
    input  wire logic [FD_W-1:0] dataIn,
    input  wire logic            readyBusyNIn
);

    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_LOW, C_HOLD} fwsr_cyc_t;

    fwsr_cyc_t            state, next_state;
    logic [PHASE_W-1:0]   cnt, next_cnt;
    logic                 wr, next_wr;
    logic [FA_W-1:0]      next_flashAddr;
    logic [FD_W-1:0]      next_dataOut, next_rdata;
    logic [FD_W:0]        s1, s2, s3, filt, next_filt;

    // Three-stage input synchronisers; a change counts once stages two and three agree.
    always_comb
    begin
        next_filt = (s2 == s3) ? s3 : filt;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1   <= {1'b1, {FD_W{1'b0}}};
            s2   <= {1'b1, {FD_W{1'b0}}};
            s3   <= {1'b1, {FD_W{1'b0}}};
            filt <= {1'b1, {FD_W{1'b0}}};
        end
        else
        begin
            s1   <= {readyBusyNIn, dataIn};
            s2   <= s1;
            s3   <= s2;
            filt <= next_filt;
        end
    end

    assign readyBusy = filt[FD_W];

    always_comb
    begin
        next_state     = state;
        next_cnt       = cnt;
        next_wr        = wr;
        next_flashAddr = flashAddr;
        next_dataOut   = dataOut;
        next_rdata     = rdata;
        done           = 1'b0;
        case (state)
            C_IDLE:
            begin
                if (start)
                begin
                    next_state     = C_SETUP;
                    next_wr        = isWrite;
                    next_flashAddr = addr;
                    next_dataOut   = wdata;
                end
            end
            C_SETUP:
            begin
                next_state = C_LOW;
                next_cnt   = wr ? PHASE_W'(WE_LOW_CYC) : PHASE_W'(OE_LOW_CYC);
            end
            C_LOW:
            begin
                if (cnt == PHASE_W'(1))
                begin
                    next_state = C_HOLD;
                    next_rdata = filt[FD_W-1:0];
                end
                else
                begin
                    next_cnt = cnt - PHASE_W'(1);
                end
            end
            C_HOLD:
            begin
                done       = 1'b1;
                next_state = C_IDLE;
            end
            default:
            begin
                next_state = C_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state     <= C_IDLE;
            cnt       <= '0;
            wr        <= 1'b0;
            flashAddr <= '0;
            dataOut   <= '0;
            rdata     <= '0;
        end
        else
        begin
            state     <= next_state;
            cnt       <= next_cnt;
            wr        <= next_wr;
            flashAddr <= next_flashAddr;
            dataOut   <= next_dataOut;
            rdata     <= next_rdata;
        end
    end

    // Data is driven across setup, strobe and hold of a write so it is stable at the rising edge.
    assign dataOe = wr && (state != C_IDLE);
    assign ceN    = (state == C_IDLE);
    assign weN    = !(wr && state == C_LOW);
    assign oeN    = !(!wr && state == C_LOW);

endmodule

// >>> fwsr_host.sv
// The plain strobed port and the register offsets are this design's own decisions.
module fwsr_host
    import fwsr_pkg::*;
(
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            rst,
    // Software register port.
    input  wire logic [7:0]      regAddr,
    input  wire logic [31:0]     regWdata,
    input  wire logic            regWr,
    input  wire logic            regRd,
    output logic [31:0]          regRdata,
    // Flash pins.
    output logic [FA_W-1:0]      flashAddr,
    output logic [FD_W-1:0]      dataOut,
    output logic                 dataOe,
    output logic                 ceN,
    output logic                 oeN,
    output logic                 weN,
    input  wire logic [FD_W-1:0] dataIn,
    input  wire logic            readyBusyNIn
);

    typedef enum logic [3:0] {
        S_IDLE, S_PRE, S_SEQ, S_RD1, S_RD2, S_CHK1, S_CHK2, S_WIN, S_RST
    } fwsr_state_t;

    fwsr_state_t      state, next_state;
    fwsr_op_t         op, next_op;
    logic             noWait, next_noWait;
    logic [FA_W-1:0]  tgtAddr, next_tgtAddr;
    logic [FD_W-1:0]  tgtData, next_tgtData;
    logic [2:0]       idx, next_idx;
    logic             waiting, next_waiting;
    logic             firstPoll, next_firstPoll;
    logic [FD_W-1:0]  first, next_first, lastRead, next_lastRead;
    logic             done, next_done, fail, next_fail;
    logic             reject, next_reject, winPre, next_winPre, winAfter, next_winAfter;
    logic [31:0]      next_regRdata;
    logic             cycStart, cycWrite, cycDone, readyBusy;
    logic [FA_W-1:0]  cycAddr;
    logic [FD_W-1:0]  cycData, cycRdata;
    logic [2:0]       seqLen;

    // Command sequence table: length, then the address and data of each write.
    always_comb
    begin
        seqLen = 3'd1;
        case (op)
            OP_PROG:   seqLen = 3'd4;
            OP_SERASE: seqLen = 3'd6;
            OP_CERASE: seqLen = 3'd6;
            default:   seqLen = 3'd1;
        endcase
    end

    always_comb
    begin
        cycAddr = tgtAddr;
        cycData = CODE_RST;
        if (!cycWrite)
        begin
            cycAddr = tgtAddr;
        end
        else if (state == S_RST || op == OP_RESET)
        begin
            cycData = CODE_RST;
        end
        else if (op == OP_SUSPEND)
        begin
            cycData = CODE_SUSP;
        end
        else if (op == OP_RESUME)
        begin
            cycData = CODE_RES;
        end
        else
        begin
            case (idx)
                3'd0:
                begin
                    cycAddr = UNLOCK_A1;
                    cycData = CODE_AA;
                end
                3'd1:
                begin
                    cycAddr = UNLOCK_A2;
                    cycData = CODE_55;
                end
                3'd2:
                begin
                    cycAddr = UNLOCK_A1;
                    cycData = (op == OP_PROG) ? CODE_PROG : CODE_ERS;
                end
                3'd3:
                begin
                    cycAddr = (op == OP_PROG) ? tgtAddr : UNLOCK_A1;
                    cycData = (op == OP_PROG) ? tgtData : CODE_AA;
                end
                3'd4:
                begin
                    cycAddr = UNLOCK_A2;
                    cycData = CODE_55;
                end
                default:
                begin
                    cycAddr = (op == OP_SERASE) ? tgtAddr : UNLOCK_A1;
                    cycData = (op == OP_SERASE) ? CODE_SECT : CODE_CHIP;
                end
            endcase
        end
    end

    assign cycWrite = (state == S_SEQ) || (state == S_RST);
    assign cycStart = (state != S_IDLE) && !waiting;

    fwsr_cycle u_cycle (
        .clk          (clk),
        .rst          (rst),
        .start        (cycStart),
        .isWrite      (cycWrite),
        .addr         (cycAddr),
        .wdata        (cycData),
        .done         (cycDone),
        .rdata        (cycRdata),
        .readyBusy    (readyBusy),
        .flashAddr    (flashAddr),
        .dataOut      (dataOut),
        .dataOe       (dataOe),
        .ceN          (ceN),
        .oeN          (oeN),
        .weN          (weN),
        .dataIn       (dataIn),
        .readyBusyNIn (readyBusyNIn)
    );

    // Sequencer and register port.
    always_comb
    begin
        next_state     = state;
        next_op        = op;
        next_noWait    = noWait;
        next_tgtAddr   = tgtAddr;
        next_tgtData   = tgtData;
        next_idx       = idx;
        next_waiting   = cycStart ? 1'b1 : waiting;
        next_firstPoll = firstPoll;
        next_first     = first;
        next_lastRead  = lastRead;
        next_done      = done;
        next_fail      = fail;
        next_reject    = reject;
        next_winPre    = winPre;
        next_winAfter  = winAfter;
        next_regRdata  = '0;
        if (regWr && state == S_IDLE)
        begin
            if (regAddr == REG_ADDR)
            begin
                next_tgtAddr = regWdata[FA_W-1:0];
            end
            if (regAddr == REG_WDATA)
            begin
                next_tgtData = regWdata[FD_W-1:0];
            end
            if (regAddr == REG_CMD)
            begin
                next_op        = fwsr_op_t'(regWdata[CMD_OP_LSB +: 3]);
                next_noWait    = regWdata[CMD_NOWAIT];
                next_idx       = 3'd0;
                next_waiting   = 1'b0;
                next_done      = 1'b0;
                next_fail      = 1'b0;
                next_reject    = 1'b0;
                next_firstPoll = 1'b1;
                case (fwsr_op_t'(regWdata[CMD_OP_LSB +: 3]))
                    OP_POLL:   next_state = S_RD1;
                    OP_READ:   next_state = S_RD1;
                    OP_SERASE: next_state = S_PRE;
                    default:   next_state = S_SEQ;
                endcase
            end
        end
        if (cycDone)
        begin
            next_waiting  = 1'b0;
            next_lastRead = cycRdata;
            case (state)
                S_PRE:
                begin
                    next_winPre = cycRdata[BIT_WINDOW] && !readyBusy;
                    next_state  = S_SEQ;
                end
                S_SEQ:
                begin
                    if (idx == seqLen - 3'd1)
                    begin
                        next_idx = 3'd0;
                        if (op == OP_RESET || op == OP_RESUME || noWait)
                        begin
                            next_state = S_IDLE;
                            next_done  = 1'b1;
                        end
                        else
                        begin
                            next_state = S_RD1;
                        end
                    end
                    else
                    begin
                        next_idx = idx + 3'd1;
                    end
                end
                S_RD1:
                begin
                    next_first = cycRdata;
                    if (op == OP_READ)
                    begin
                        next_state = S_IDLE;
                        next_done  = 1'b1;
                    end
                    else
                    begin
                        next_state = S_RD2;
                    end
                end
                S_RD2:
                begin
                    if (cycRdata[BIT_TOGGLE_A] == first[BIT_TOGGLE_A])
                    begin
                        next_state = (op == OP_SERASE && firstPoll) ? S_WIN : S_IDLE;
                        next_done  = !(op == OP_SERASE && firstPoll);
                    end
                    else if (op == OP_SERASE && firstPoll)
                    begin
                        next_state = S_WIN;
                    end
                    else if (cycRdata[BIT_TIMEOUT])
                    begin
                        next_state = S_CHK1;
                    end
                    else
                    begin
                        next_state = S_RD1;
                    end
                end
                S_WIN:
                begin
                    next_winAfter  = cycRdata[BIT_WINDOW];
                    next_reject    = winPre;
                    next_firstPoll = 1'b0;
                    next_state     = S_RD1;
                end
                S_CHK1:
                begin
                    next_first = cycRdata;
                    next_state = S_CHK2;
                end
                S_CHK2:
                begin
                    if (cycRdata[BIT_TOGGLE_A] == first[BIT_TOGGLE_A])
                    begin
                        next_state = S_IDLE;
                        next_done  = 1'b1;
                    end
                    else
                    begin
                        next_fail  = 1'b1;
                        next_state = S_RST;
                    end
                end
                S_RST:
                begin
                    next_state = S_IDLE;
                    next_done  = 1'b1;
                end
                default:
                begin
                    next_state = S_IDLE;
                end
            endcase
        end
        if (regRd)
        begin
            case (regAddr)
                REG_CMD:    next_regRdata = {27'h0, noWait, 1'b0, op};
                REG_ADDR:   next_regRdata = {12'h0, tgtAddr};
                REG_WDATA:  next_regRdata = {24'h0, tgtData};
                REG_RDATA:  next_regRdata = {24'h0, lastRead};
                REG_STATUS:
                begin
                    next_regRdata[ST_BUSY]      = (state != S_IDLE);
                    next_regRdata[ST_DONE]      = done;
                    next_regRdata[ST_FAIL]      = fail;
                    next_regRdata[ST_REJECT]    = reject;
                    next_regRdata[ST_WIN_AFTER] = winAfter;
                    next_regRdata[ST_RDY]       = readyBusy;
                    next_regRdata[ST_WIN_PRE]   = winPre;
                end
                default:    next_regRdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state     <= S_IDLE;
            op        <= OP_POLL;
            noWait    <= 1'b0;
            tgtAddr   <= '0;
            tgtData   <= '0;
            idx       <= '0;
            waiting   <= 1'b0;
            firstPoll <= 1'b0;
            first     <= '0;
            lastRead  <= '0;
            done      <= 1'b0;
            fail      <= 1'b0;
            reject    <= 1'b0;
            winPre    <= 1'b0;
            winAfter  <= 1'b0;
            regRdata  <= '0;
        end
        else
        begin
            state     <= next_state;
            op        <= next_op;
            noWait    <= next_noWait;
            tgtAddr   <= next_tgtAddr;
            tgtData   <= next_tgtData;
            idx       <= next_idx;
            waiting   <= next_waiting;
            firstPoll <= next_firstPoll;
            first     <= next_first;
            lastRead  <= next_lastRead;
            done      <= next_done;
            fail      <= next_fail;
            reject    <= next_reject;
            winPre    <= next_winPre;
            winAfter  <= next_winAfter;
            regRdata  <= next_regRdata;
        end
    end

endmodule

// >>> fwsr_host_properties.sv
module fwsr_host_checker
    import fwsr_pkg::*;
(
    // Clock and reset.
    input wire logic            clk,
    input wire logic            rst,
    // Watched ports.
    input wire logic            regRd,
    input wire logic [31:0]     regRdata,
    input wire logic [FA_W-1:0] flashAddr,
    input wire logic [FD_W-1:0] dataOut,
    input wire logic            dataOe,
    input wire logic            ceN,
    input wire logic            oeN,
    input wire logic            weN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence weLow;
        !weN [*2] ##1 weN;
    endsequence
    sequence oeLow;
        !oeN [*6] ##1 oeN;
    endsequence
    sequence holdEnd;
        !ceN ##1 ceN;
    endsequence
    we_width_a: assert property ($fell(weN) |-> weLow)
        else $error("write strobe width wrong");
    oe_width_a: assert property ($fell(oeN) |-> oeLow)
        else $error("read strobe width wrong");
    we_hold_a: assert property ($rose(weN) |-> holdEnd)
        else $error("write hold wrong");
    we_setup_a: assert property ($fell(weN) |-> !$past(ceN) && $past(dataOe))
        else $error("write setup missing");
    strobe_excl_a: assert property (!(!oeN && !weN))
        else $error("read and write strobes together");
    read_float_a: assert property (!oeN |-> !dataOe)
        else $error("bus driven during read");
    bus_stable_a: assert property (!ceN && !$past(ceN) |-> $stable(flashAddr) && $stable(dataOut))
        else $error("address or data moved in cycle");
    idle_gap_a: assert property ($rose(weN) || $rose(oeN) |=> ceN)
        else $error("no idle cycle between bus cycles");
    rdata_pulse_a: assert property (regRdata != 0 |-> $past(regRd))
        else $error("read data outside answer cycle");
endmodule
bind fwsr_host fwsr_host_checker chk (.clk(clk), .rst(rst), .regRd(regRd),
    .regRdata(regRdata), .flashAddr(flashAddr), .dataOut(dataOut), .dataOe(dataOe),
    .ceN(ceN), .oeN(oeN), .weN(weN));

// >>> fwsr_flash_model.sv
module fwsr_flash_model
    import fwsr_pkg::*;
#(
    parameter int BUSY_RD = 4,
    parameter int WIN_RD  = 2,
    parameter logic [3:0] PROT_SECT = 4'hf
)
(
    // Flash pins.
    input  wire logic            ceN,
    input  wire logic            oeN,
    input  wire logic            weN,
    input  wire logic [FA_W-1:0] addr,
    input  wire logic [FD_W-1:0] din,
    output logic [FD_W-1:0]      dout,
    output logic                 rbLow,
    // Reset commands seen.
    output int                   resets
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [FD_W-1:0] mem [int];
    logic [FD_W-1:0] last, pd;
    logic            prog, ers, susp, fail, tA, tB, prot, skip;
    int              busy, win;
    initial
    begin
        {last, pd, prog, ers, susp, fail, tA, tB, prot, skip} = '0;
        busy = 0;
        win = 0;
        resets = 0;
        dout = 8'h00;
    end
    assign rbLow = busy > 0 && !susp;
    always @(posedge weN)
    begin
        if (din == CODE_RST)
        begin
            busy = 0;
            fail = 0;
            {prog, ers, susp} = '0;
            resets++;
        end
        else if (busy > 0)
        begin
            if (din == CODE_SUSP && ers)
                susp = 1'h1;
            else if (din == CODE_RES && susp)
                susp = 1'h0;
        end
        else if (last == CODE_PROG)
        begin
            pd = din;
            prot = addr[FA_W-1:FA_W-4] == PROT_SECT;
            fail = !prot && |(din & ~(mem.exists(addr) ? mem[addr] : 8'hff));
            if (!fail && !prot) mem[addr] = din;
            prog = 1'h1;
            busy = BUSY_RD;
        end
        else if (last == CODE_55 && (din == CODE_SECT || din == CODE_CHIP))
        begin
            ers = 1'h1;
            skip = addr[FA_W-1:FA_W-4] == PROT_SECT && din == CODE_SECT;
            win = din == CODE_SECT ? WIN_RD : 0;
            busy = BUSY_RD;
        end
        last = din;
    end
    always @(negedge oeN)
    begin
        if (busy > 0)
            dout = {prog ? ~pd[7] : susp, tA, fail, 1'h0, win == 0, tB, 2'h0};
        else
            dout = mem.exists(addr) ? mem[addr] : 8'hff;
    end
    always @(posedge oeN)
    begin
        dout = ~dout;
        if (busy > 0)
        begin
            tA = tA ^ !susp;
            tB = tB ^ ers;
            if (win > 0)
                win--;
            else if (!susp && !fail)
                busy--;
            if (busy == 0)
            begin
                if (ers && !skip) mem.delete();
                prog = 1'h0;
                ers = 1'h0;
            end
        end
    end
endmodule

// >>> fwsr_host_tb_top.sv
module fwsr_host_tb_top;
    import fwsr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic            clk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0, sawBusy;
    logic [7:0]      regAddr = 8'h00;
    logic [31:0]     regWdata = 32'h0, regRdata, s;
    logic [FA_W-1:0] flashAddr;
    logic [FD_W-1:0] dataOut, flashOut, dataBus;
    logic            dataOe, ceN, oeN, weN, rbLow;
    int              bad_count = 0, samples_checked = 0, cycles = 0, resets;
    assign dataBus = dataOe ? dataOut : flashOut;
    always #20 clk = ~clk;
    fwsr_host DUT (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr), .dataOut(dataOut),
        .dataOe(dataOe), .ceN(ceN), .oeN(oeN), .weN(weN), .dataIn(dataBus),
        .readyBusyNIn(!rbLow));
    fwsr_flash_model flash (.ceN(ceN), .oeN(oeN), .weN(weN), .addr(flashAddr), .din(dataBus),
        .dout(flashOut), .rbLow(rbLow), .resets(resets));
    task automatic results();
        $display("compared %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            bad_count++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge clk);
        regWr <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clk);
        regRd <= 1'h0;
        #1 s = regRdata;
    endtask
    task automatic run(input logic [31:0] c);
        int n;
        n = 0;
        sawBusy = 1'h0;
        s = 32'h1;
        wr(REG_CMD, c);
        while (s[ST_BUSY] === 1'h1 && n < 5000)
        begin
            rd(REG_STATUS);
            if (s[ST_RDY] === 1'h0) sawBusy = 1'h1;
            n++;
        end
    endtask
    task automatic readBack(input logic [31:0] e);
        run(32'(OP_READ));
        rd(REG_RDATA);
        chk(s, e);
    endtask
    task automatic t_idle();
        rd(REG_STATUS);
        chk(s & 32'h27, 32'h20);
        rd(8'h20);
        chk(s, 32'h0);
    endtask
    task automatic t_prog();
        wr(REG_ADDR, 32'h12345);
        wr(REG_WDATA, 32'h5a);
        run(32'(OP_PROG));
        chk({s[ST_FAIL], s[ST_DONE], sawBusy}, 3'h3);
        readBack(32'h5a);
    endtask
    task automatic t_fail();
        int n;
        n = resets;
        wr(REG_WDATA, 32'hff);
        run(32'(OP_PROG));
        chk({s[ST_BUSY], s[ST_FAIL], s[ST_DONE]}, 3'h3);
        chk(resets, n + 1);
        readBack(32'h5a);
    endtask
    task automatic t_erase();
        run(32'(OP_SERASE));
        chk({s[ST_WIN_AFTER], s[ST_WIN_PRE], s[ST_REJECT], s[ST_FAIL], s[ST_DONE]}, 5'h11);
        readBack(32'hff);
    endtask
    task automatic t_susp();
        run(32'(OP_SERASE) | (32'h1 << CMD_NOWAIT));
        run(32'(OP_SUSPEND));
        rd(REG_STATUS);
        chk({s[ST_RDY], s[ST_DONE]}, 2'h3);
        run(32'(OP_RESUME));
        run(32'(OP_POLL));
        chk({s[ST_FAIL], s[ST_DONE], sawBusy}, 3'h3);
    endtask
    task automatic t_prot();
        wr(REG_ADDR, 32'hf0000);
        wr(REG_WDATA, 32'h00);
        run(32'(OP_PROG));
        chk({s[ST_FAIL], s[ST_DONE], sawBusy}, 3'h3);
        readBack(32'hff);
        wr(REG_ADDR, 32'h12345);
        run(32'(OP_PROG));
        wr(REG_ADDR, 32'hf0000);
        run(32'(OP_SERASE));
        chk({s[ST_FAIL], s[ST_DONE]}, 2'h1);
        wr(REG_ADDR, 32'h12345);
        readBack(32'h00);
    endtask
    task automatic t_chip();
        int n;
        wr(REG_WDATA, 32'h00);
        run(32'(OP_PROG));
        run(32'(OP_CERASE));
        chk({s[ST_FAIL], s[ST_DONE], sawBusy}, 3'h3);
        readBack(32'hff);
        n = resets;
        run(32'(OP_RESET));
        chk(resets, n + 1);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        t_idle();
        t_prog();
        t_fail();
        t_erase();
        t_susp();
        t_prot();
        t_chip();
        results();
    end
endmodule
